// ### verilog/store_check_map.vh
// named offsets, fields, codes and limits of the store issue and check unit
`ifndef STORE_CHECK_MAP_VH
`define STORE_CHECK_MAP_VH
// ---------------------------------------------------------------
// operation selector codes
// ---------------------------------------------------------------
`define OP_BYTE 4'h0
`define OP_HALF 4'h1
`define OP_WORD 4'h2
`define OP_DWORD 4'h3
`define OP_BYTE_SPACE 4'h4
`define OP_HALF_SPACE 4'h5
`define OP_WORD_SPACE 4'h6
`define OP_DWORD_SPACE 4'h7
`define OP_BLOCK 4'h8
// ---------------------------------------------------------------
// instruction word fields
// ---------------------------------------------------------------
`define IMM_SEL_BIT 13
`define IMM_HI 12
`define RSV_HI 12
`define RSV_LO 5
`define SPACE_HI 12
`define SPACE_LO 5
// ---------------------------------------------------------------
// address space identifier limits
// ---------------------------------------------------------------
`define SPACE_UNPRIV_BIT 7
`define SPACE_PRIV_LO 8'h30
`define SPACE_PRIV_HI 8'h7f
`define SPACE_OK_A_LO 8'h04
`define SPACE_OK_A_HI 8'h11
`define SPACE_OK_B_LO 8'h80
`define SPACE_OK_B_HI 8'h89
`define SPACE_EXCL_LO 8'hc0
`define SPACE_EXCL_HI 8'hc7
`define SPACE_BLK_P 8'hf0
`define SPACE_BLK_S 8'hf1
`define SPACE_BLK_PL 8'hf8
`define SPACE_BLK_SL 8'hf9
// ---------------------------------------------------------------
// register offsets and fields
// ---------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_STATE 8'h0c
`define EVT_W 5
`define EVT_BAD_OP 0
`define EVT_PRIV 1
`define EVT_SPACE 2
`define EVT_ALIGN 3
`define EVT_DONE 4
`define CTRL_RESET 1'b1
// ---------------------------------------------------------------
// trap codes, block geometry
// ---------------------------------------------------------------
`define TRAP_NONE 3'h0
`define TRAP_BAD_OP 3'h1
`define TRAP_PRIV 3'h2
`define TRAP_SPACE 3'h3
`define TRAP_ALIGN 3'h4
`define BLK_LAST 3'h7
`define BLK_ALIGN_BITS 6
`define BEAT_BYTES 64'h8
`endif

// ### verilog/block_stage_mem.v
// staging memory for the eight doublewords of a block store
`timescale 1ns/100ps
`default_nettype none
module block_stage_mem (
  input wire clk,
  input wire we,
  input wire [2:0] waddr,
  input wire [63:0] wdata,
  input wire [2:0] raddr,
  output reg [63:0] rdata_q
);
  reg [63:0] mem [0:7];

  // write port and registered read port; no reset, contents come from the pipeline
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// ### verilog/store_issue_check_unit.v
// store issue and check unit: address forming, trap checks, memory store requests
// Behaviour
// - plain stores write the whole register, its low word, low halfword or low byte as the opcode says.
// - the address is first plus second source when the immediate select is clear, else first plus signed immediate.
// - a plain store with immediate select clear and nonzero bits 12 to 5 raises the bad-opcode trap.
// - plain halfword, word and doubleword stores trap on a misaligned address; bytes never do.
// - alternate halfword, word and doubleword stores trap on misalignment; the alternate byte store never does.
// - a store without trap other than a block store goes out as one single request so it is never seen half written.
// - the alternate space comes from the instruction field when the select is clear, else from the space register.
// - in nonprivileged mode an alternate store traps for privilege when space bit 7 is zero.
// - in privileged mode an alternate store traps for privilege when the space lies in 30 to 7f.
// - alternate byte, halfword and word stores raise the invalid-space trap outside the permitted set.
// - the alternate doubleword store accepts any space except an excluded set.
// - a block store must use one of the block-transfer spaces, which reach the normal address space.
// - a block store writes little-endian for the little-endian block spaces and big-endian otherwise.
// - little-endian swapping is done inside each of the eight doublewords, not across the block.
// - a block store writes eight registers in order, the lowest register to the lowest eight bytes.
// - a block store traps on misalignment when any of the low six address bits is set.
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "store_check_map.vh"
module store_issue_check_unit (
  input wire clk,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq_o,
  input wire issue_valid,
  output reg issue_ready,
  input wire [3:0] op_sel,
  input wire [31:0] instr,
  input wire [63:0] first_source_reg,
  input wire [63:0] second_source_reg,
  input wire [63:0] store_data,
  input wire [7:0] space_reg,
  input wire privileged_mode_bit,
  input wire stage_we,
  input wire [2:0] stage_idx,
  input wire [63:0] stage_data,
  output reg trap_valid,
  output reg [2:0] trap_code,
  output reg mem_valid,
  input wire mem_ready,
  output reg [63:0] mem_addr,
  output reg [63:0] mem_data,
  output reg [7:0] mem_be,
  output reg [7:0] mem_space
);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_SEND = 2'd1;
  localparam [1:0] S_FETCH = 2'd2;
  localparam [1:0] S_LOAD = 2'd3;
  // space value used for the implicit address space
  parameter [7:0] IMPLICIT_SPACE = 8'h80;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function in_range;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  function is_block_space;
    input [7:0] s;
    begin
      is_block_space = (s == `SPACE_BLK_P) || (s == `SPACE_BLK_S) ||
                       (s == `SPACE_BLK_PL) || (s == `SPACE_BLK_SL);
    end
  endfunction

  // big-endian lanes: lane 7 carries the byte at offset 0
  function [7:0] lane_mask;
    input [1:0] size;
    input [2:0] off;
    begin
      case (size)
        2'd0: lane_mask = 8'h80 >> off;
        2'd1: lane_mask = 8'hc0 >> off;
        2'd2: lane_mask = 8'hf0 >> off;
        default: lane_mask = 8'hff;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // operation decode and address forming
  // ---------------------------------------------------------------
  wire imm_sel = instr[`IMM_SEL_BIT];
  wire [63:0] imm_ext = {{51{instr[`IMM_HI]}}, instr[`IMM_HI:0]};
  wire [63:0] eff_addr = first_source_reg + (imm_sel ? imm_ext : second_source_reg);
  wire [7:0] alt_space = imm_sel ? space_reg : instr[`SPACE_HI:`SPACE_LO];
  wire is_plain = (op_sel <= `OP_DWORD);
  wire is_alt = (op_sel >= `OP_BYTE_SPACE) && (op_sel <= `OP_BLOCK);
  wire is_block = (op_sel == `OP_BLOCK);
  wire op_known = is_plain || is_alt;
  wire [1:0] size = op_sel[1:0];
  wire [7:0] sel_space = is_alt ? alt_space : IMPLICIT_SPACE;

  // ---------------------------------------------------------------
  // trap conditions
  // ---------------------------------------------------------------
  reg bad_op;
  reg priv_bad;
  reg space_bad;
  reg align_bad;
  reg [2:0] trap_sel;
  always @* begin
    // unknown selectors are treated like an illegal encoding
    bad_op = !op_known || (is_plain && !imm_sel && (instr[`RSV_HI:`RSV_LO] != 8'h00));
    priv_bad = is_alt && ((!privileged_mode_bit && !sel_space[`SPACE_UNPRIV_BIT]) ||
               (privileged_mode_bit && in_range(sel_space, `SPACE_PRIV_LO, `SPACE_PRIV_HI)));
    space_bad = 1'b0;
    if (is_block) begin
      space_bad = !is_block_space(sel_space);
    end else if (op_sel == `OP_DWORD_SPACE) begin
      space_bad = in_range(sel_space, `SPACE_EXCL_LO, `SPACE_EXCL_HI);
    end else if (is_alt) begin
      space_bad = !(in_range(sel_space, `SPACE_OK_A_LO, `SPACE_OK_A_HI) ||
                    in_range(sel_space, `SPACE_OK_B_LO, `SPACE_OK_B_HI));
    end
    // byte sizes need no alignment; block needs six clear bits
    if (is_block) begin
      align_bad = (eff_addr[`BLK_ALIGN_BITS-1:0] != 6'h00);
    end else begin
      case (size)
        2'd1: align_bad = eff_addr[0];
        2'd2: align_bad = (eff_addr[1:0] != 2'h0);
        2'd3: align_bad = (eff_addr[2:0] != 3'h0);
        default: align_bad = 1'b0;
      endcase
    end
    // fixed ranking of simultaneous traps
    if (bad_op) begin
      trap_sel = `TRAP_BAD_OP;
    end else if (priv_bad) begin
      trap_sel = `TRAP_PRIV;
    end else if (space_bad) begin
      trap_sel = `TRAP_SPACE;
    end else if (align_bad) begin
      trap_sel = `TRAP_ALIGN;
    end else begin
      trap_sel = `TRAP_NONE;
    end
  end

  // ---------------------------------------------------------------
  // store data lanes and block byte swap
  // ---------------------------------------------------------------
  reg [63:0] lane_data;
  always @* begin
    // replicate the low part so any lane selected by the mask carries it
    case (size)
      2'd0: lane_data = {8{store_data[7:0]}};
      2'd1: lane_data = {4{store_data[15:0]}};
      2'd2: lane_data = {2{store_data[31:0]}};
      default: lane_data = store_data;
    endcase
  end

  wire [63:0] blk_raw;
  wire [63:0] blk_swapped;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : swap
      // swap stays inside one doubleword
      assign blk_swapped[8*g+7:8*g] = blk_raw[63-8*g:56-8*g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // issue and memory request sequencer
  // ---------------------------------------------------------------
  reg [1:0] state_q;
  reg [2:0] beat_q;
  reg blk_le_q;
  reg [63:0] blk_base_q;
  reg ctrl_en_q;
  reg is_blk_run;
  wire take = issue_valid && issue_ready;

  block_stage_mem stage (
    .clk(clk),
    .we(stage_we),
    .waddr(stage_idx),
    .wdata(stage_data),
    .raddr(beat_q),
    .rdata_q(blk_raw)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      beat_q <= 3'h0;
      blk_le_q <= 1'b0;
      blk_base_q <= 64'h0;
      issue_ready <= 1'b0;
      trap_valid <= 1'b0;
      trap_code <= `TRAP_NONE;
      mem_valid <= 1'b0;
      mem_addr <= 64'h0;
      mem_data <= 64'h0;
      mem_be <= 8'h00;
      mem_space <= 8'h00;
    end else begin
      trap_valid <= 1'b0;
      case (state_q)
        S_IDLE: begin
          issue_ready <= ctrl_en_q;
          if (take) begin
            issue_ready <= 1'b0;
            trap_code <= trap_sel;
            if (trap_sel != `TRAP_NONE) begin
              trap_valid <= 1'b1;
            end else if (is_block) begin
              blk_base_q <= eff_addr;
              blk_le_q <= (sel_space == `SPACE_BLK_PL) || (sel_space == `SPACE_BLK_SL);
              mem_space <= sel_space;
              beat_q <= 3'h0;
              state_q <= S_FETCH;
            end else begin
              // whole store in one request keeps it atomic
              mem_valid <= 1'b1;
              mem_addr <= {eff_addr[63:3], 3'h0};
              mem_data <= lane_data;
              mem_be <= lane_mask(size, eff_addr[2:0]);
              mem_space <= sel_space;
              state_q <= S_SEND;
            end
          end
        end
        S_FETCH: begin
          // one cycle for the registered staging read
          state_q <= S_LOAD;
        end
        S_LOAD: begin
          mem_valid <= 1'b1;
          mem_addr <= blk_base_q + {58'h0, beat_q, 3'h0};
          mem_data <= blk_le_q ? blk_swapped : blk_raw;
          mem_be <= 8'hff;
          state_q <= S_SEND;
        end
        S_SEND: begin
          if (mem_ready) begin
            mem_valid <= 1'b0;
            if (is_blk_run && (beat_q != `BLK_LAST)) begin
              beat_q <= beat_q + 3'h1;
              state_q <= S_FETCH;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // a block run is any send whose data was staged
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      is_blk_run <= 1'b0;
    end else if (state_q == S_IDLE) begin
      is_blk_run <= take && is_block && (trap_sel == `TRAP_NONE);
    end
  end

  // ---------------------------------------------------------------
  // events, interrupt and wishbone slave
  // ---------------------------------------------------------------
  reg [`EVT_W-1:0] status_q;
  reg [`EVT_W-1:0] mask_q;
  reg [`EVT_W-1:0] evt;
  wire done_evt = (state_q == S_SEND) && mem_ready && !(is_blk_run && (beat_q != `BLK_LAST));
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire rd_take = bus_req && !wb_we_i && !wb_ack_o;
  wire wr_take = bus_req && wb_we_i && wb_ack_o;

  always @* begin
    evt = {`EVT_W{1'b0}};
    evt[`EVT_BAD_OP] = trap_valid && (trap_code == `TRAP_BAD_OP);
    evt[`EVT_PRIV] = trap_valid && (trap_code == `TRAP_PRIV);
    evt[`EVT_SPACE] = trap_valid && (trap_code == `TRAP_SPACE);
    evt[`EVT_ALIGN] = trap_valid && (trap_code == `TRAP_ALIGN);
    evt[`EVT_DONE] = done_evt;
  end

  wire clr_status = rd_take && (wb_adr_i == `REG_STATUS);
  // a new event in the clearing cycle survives: set wins
  wire [`EVT_W-1:0] status_d = (clr_status ? {`EVT_W{1'b0}} : status_q) | evt;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= {`EVT_W{1'b0}};
      mask_q <= {`EVT_W{1'b0}};
      ctrl_en_q <= `CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      irq_o <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_o <= |(status_d & mask_q);
      // ack one cycle after the strobe, dropped the cycle after
      wb_ack_o <= bus_req && !wb_ack_o;
      if (rd_take) begin
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= {31'h0, ctrl_en_q};
          `REG_STATUS: wb_dat_o <= {27'h0, status_q};
          `REG_MASK: wb_dat_o <= {27'h0, mask_q};
          `REG_STATE: wb_dat_o <= {24'h0, beat_q, state_q, trap_code};
          default: wb_dat_o <= 32'h0;
        endcase
      end
      // writes land on the edge where the master sees ack
      if (wr_take && wb_sel_i[0]) begin
        if (wb_adr_i == `REG_CTRL) begin
          ctrl_en_q <= wb_dat_i[0];
        end
        if (wb_adr_i == `REG_MASK) begin
          mask_q <= wb_dat_i[`EVT_W-1:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/store_issue_check_props.sv
// assertion checker for the store issue and check unit
`timescale 1ns/100ps
`default_nettype none
module store_issue_check_props (
  input wire clk,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire issue_valid,
  input wire issue_ready,
  input wire [3:0] op_sel,
  input wire [31:0] instr,
  input wire [7:0] space_reg,
  input wire privileged_mode_bit,
  input wire trap_valid,
  input wire [2:0] trap_code,
  input wire mem_valid,
  input wire mem_ready,
  input wire [63:0] mem_addr,
  input wire [63:0] mem_data
);
  // ---------------------------------------------------------------
  // clocking, helper terms and sequences
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // space as the instruction selects it; only meaningful for alternate ops
  wire [7:0] sel_space = instr[13] ? space_reg : instr[12:5];
  sequence take_s;
    issue_valid && issue_ready;
  endsequence
  sequence answer_s;
    ##[0:2] (trap_valid || mem_valid);
  endsequence
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not answered in the next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  store_answer_a: assert property (take_s |=> answer_s)
    else $error("accepted store got neither trap nor memory request");
  issue_busy_a: assert property (take_s |=> !issue_ready)
    else $error("issue ready stayed high after a store was taken");
  no_write_trap_a: assert property (trap_valid |-> !mem_valid)
    else $error("memory request alongside a trap");
  bad_opcode_a: assert property (take_s ##0 (op_sel < 4'h4 && !instr[13] && instr[12:5] != 8'h00)
    |=> trap_valid && trap_code == 3'h1) else $error("reserved bits set but no bad opcode trap");
  byte_free_a: assert property (take_s ##0 (op_sel == 4'h0 && (instr[13] || instr[12:5] == 8'h00))
    |=> !trap_valid && mem_valid) else $error("plain byte store did not go out next cycle");
  priv_user_a: assert property (take_s ##0 (op_sel[3:2] == 2'b01 && !privileged_mode_bit && !sel_space[7])
    |=> trap_valid && trap_code == 3'h2) else $error("user space access not refused");
  priv_super_a: assert property (take_s ##0 (op_sel[3:2] == 2'b01 && privileged_mode_bit
    && sel_space >= 8'h30 && sel_space <= 8'h7f) |=> trap_code == 3'h2) else $error("restricted space not refused");
  mem_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_data))
    else $error("memory request changed before it was accepted");
endmodule
bind store_issue_check_unit store_issue_check_props i_props (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .issue_valid(issue_valid), .issue_ready(issue_ready),
  .op_sel(op_sel), .instr(instr), .space_reg(space_reg), .privileged_mode_bit(privileged_mode_bit),
  .trap_valid(trap_valid), .trap_code(trap_code), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .mem_addr(mem_addr), .mem_data(mem_data));
`default_nettype wire

// ### tb/mem_partner.sv
// memory-side responder model that accepts store beats
`timescale 1ns/100ps
`default_nettype none
module mem_partner (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mem_valid,
  input wire logic [1:0] delay,
  output logic mem_ready
);
  logic [1:0] wait_q;
  // ready after delay cycles of valid; a one-cycle pulse so no beat is taken twice
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ready <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      mem_ready <= mem_valid && !mem_ready && wait_q >= delay;
      wait_q <= (mem_valid && !mem_ready && wait_q < delay) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ### tb/store_issue_check_unit_tb.sv
// self-checking bench of the store issue and check unit
`timescale 1ns/100ps
`default_nettype none
`include "store_check_map.vh"
module store_issue_check_unit_tb;
  // ---------------------------------------------------------------
  // stimulus, design and partner
  // ---------------------------------------------------------------
  localparam [7:0] IMPL = 8'h80;
  logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, iv = 1'b0, pv = 1'b0, sw = 1'b0;
  logic [7:0] adr = 8'h00, sreg = 8'h00, mem_be, mem_space;
  logic [31:0] wdat = 32'h0, ins = 32'h0, wb_dat_o, r;
  logic [3:0] op = 4'h0;
  logic [63:0] rs1 = 64'h0, rs2 = 64'h0, sd = 64'h0, sdat = 64'h0, mem_addr, mem_data;
  logic [2:0] sidx = 3'h0, trap_code;
  logic [1:0] dly = 2'h0;
  logic wb_ack_o, irq_o, issue_ready, trap_valid, mem_valid, mem_ready;
  logic [63:0] qa[$], qd[$], stg[8];
  logic [7:0] qb[$], qs[$];
  integer seed, n_mismatch = 0, samples_checked = 0;
  always #25 clk = ~clk;
  store_issue_check_unit #(.IMPLICIT_SPACE(IMPL)) i_store_issue_check_unit (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .issue_valid(iv), .issue_ready(issue_ready),
    .op_sel(op), .instr(ins), .first_source_reg(rs1), .second_source_reg(rs2), .store_data(sd),
    .space_reg(sreg), .privileged_mode_bit(pv), .stage_we(sw), .stage_idx(sidx), .stage_data(sdat),
    .trap_valid(trap_valid), .trap_code(trap_code), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_be(mem_be), .mem_space(mem_space));
  mem_partner i_mem_partner (.clk(clk), .reset_n(reset_n), .mem_valid(mem_valid), .delay(dly),
    .mem_ready(mem_ready));
  // log every accepted beat; the store task compares against the log afterwards
  always @(posedge clk) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      qa.push_back(mem_addr);
      qd.push_back(mem_data);
      qb.push_back(mem_be);
      qs.push_back(mem_space);
    end
  end
  // ---------------------------------------------------------------
  // expectation functions and tasks
  // ---------------------------------------------------------------
  function automatic bit in_rng(input [7:0] v, input [7:0] lo, input [7:0] hi);
    return v >= lo && v <= hi;
  endfunction
  function automatic [2:0] trap_of(input [3:0] o, input [31:0] i, input [63:0] e, input [7:0] s, input p);
    if (o > 4'h8 || (o < 4'h4 && !i[13] && i[12:5] != 8'h00)) return 3'h1;
    if (o >= 4'h4 && (p ? in_rng(s, 8'h30, 8'h7f) : !s[7])) return 3'h2;
    if (o == 4'h8 ? !(s[7:1] == 7'h78 || s[7:1] == 7'h7c) : o[3:2] == 2'b01 && (o[1:0] == 2'h3 ?
      in_rng(s, 8'hc0, 8'hc7) : !(in_rng(s, 8'h04, 8'h11) || in_rng(s, 8'h80, 8'h89)))) return 3'h3;
    if (o == 4'h8 ? e[5:0] != 6'h0 : (e[2:0] & ((3'h1 << o[1:0]) - 3'h1)) != 3'h0) return 3'h4;
    return 3'h0;
  endfunction
  function automatic [63:0] data_of(input [1:0] z, input [63:0] v);
    case (z)
      2'h0: return {8{v[7:0]}};
      2'h1: return {4{v[15:0]}};
      2'h2: return {2{v[31:0]}};
      default: return v;
    endcase
  endfunction
  function automatic [63:0] swap(input [63:0] d);
    for (int k = 0; k < 8; k++) swap[8*k +: 8] = d[56-8*k +: 8];
  endfunction
  task automatic chk(input string nm, input [63:0] e, input [63:0] g);
    samples_checked++;
    if (e !== g) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic bus cycle, entered just after a rising edge
  task automatic wb(input w, input [7:0] a, input [31:0] d, output [31:0] rd);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; n = 0;
    do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      chk("bus ack", 1, 0);
      end_of_test;
    end
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic st(input [3:0] o, input [31:0] i, input [63:0] a, input [63:0] b, input [63:0] v,
    input [7:0] s, input p);
    int n, q0;
    logic [63:0] e;
    logic [7:0] sp;
    logic [2:0] t;
    e = a + (i[13] ? {{51{i[12]}}, i[12:0]} : b);
    sp = (o < 4'h4) ? IMPL : (i[13] ? s : i[12:5]);
    t = trap_of(o, i, e, sp, p);
    q0 = qa.size();
    op <= o; ins <= i; rs1 <= a; rs2 <= b; sd <= v; sreg <= s; pv <= p; iv <= 1'b1; n = 0;
    do begin @(posedge clk); n++; end while (issue_ready !== 1'b1 && n < 50);
    if (issue_ready !== 1'b1) begin
      chk("issue ready", 1, 0);
      end_of_test;
    end
    iv <= 1'b0;
    @(posedge clk);
    chk("trap_valid", t != 3'h0, trap_valid);
    if (t != 3'h0) chk("trap_code", t, trap_code);
    else begin
      n = 0;
      while (qa.size() < q0 + (o == 4'h8 ? 8 : 1) && n < 200) begin @(posedge clk); n++; end
      if (qa.size() < q0 + (o == 4'h8 ? 8 : 1)) begin
        chk("beat count", 1, 0);
        end_of_test;
      end
      else if (o == 4'h8) for (int k = 0; k < 8; k++) begin
        chk("block addr", e + 8 * k, qa[q0+k]);
        chk("block data", sp[3] ? swap(stg[k]) : stg[k], qd[q0+k]);
      end else begin
        chk("addr", {e[63:3], 3'h0}, qa[q0]);
        chk("space", sp, qs[q0]);
        chk("lanes", 8'((8'hff << (4'h8 - (4'h1 << o[1:0]))) >> e[2:0]), qb[q0]);
        chk("data", data_of(o[1:0], v), qd[q0]);
      end
    end
  endtask
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hd976d038;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    wb(1'b0, `REG_CTRL, 0, r); chk("ctrl", 1, r);
    wb(1'b0, `REG_MASK, 0, r); chk("mask", 0, r);
    wb(1'b0, 8'h10, 0, r); chk("unmapped", 0, r);
    st(`OP_HALF, 32'h20, 64'h1000, 64'h1, 64'h1234, 8'h00, 1'b0);
    st(`OP_WORD, 32'h2002, 64'h1000, 0, 64'h55, 8'h00, 1'b0);
    st(`OP_BYTE, 32'h3fff, 64'h1000, 0, 64'ha5, 8'h00, 1'b0);
    st(`OP_DWORD, 0, 64'h1008, 64'h8, 64'h0123456789abcdef, 8'h00, 1'b0);
    st(`OP_BYTE_SPACE, 32'h2001, 64'h1000, 0, 64'h3c, 8'h80, 1'b0);
    st(`OP_HALF_SPACE, 32'h1000, 64'h1000, 64'h1, 64'h77, 8'h00, 1'b1);
    st(`OP_WORD_SPACE, 32'h2000, 64'h1001, 0, 64'h1, 8'h04, 1'b0);
    st(`OP_WORD_SPACE, 32'h2000, 64'h1000, 0, 64'h1, 8'h40, 1'b1);
    st(`OP_WORD_SPACE, 32'h2000, 64'h1000, 0, 64'h1, 8'h20, 1'b1);
    st(`OP_DWORD_SPACE, 32'h2000, 64'h1000, 0, 64'h9, 8'h20, 1'b1);
    st(`OP_DWORD_SPACE, 32'h2000, 64'h1000, 0, 64'h9, 8'hc3, 1'b1);
    st(4'h9, 32'h2000, 64'h1000, 0, 64'h9, 8'h80, 1'b1);
    repeat (80) begin
      dly <= 2'($random(seed));
      st($random(seed) & 7, ($random(seed) & 1) ? 32'h2000 | ($random(seed) & 32'h1fff) : 32'h0,
        64'h4000 + ($random(seed) & 15), $random(seed) & 7, {$random(seed), $random(seed)},
        $random(seed), $random(seed));
    end
    for (int k = 0; k < 8; k++) begin
      stg[k] = {$random(seed), $random(seed)};
      sw <= 1'b1; sidx <= 3'(k); sdat <= stg[k];
      @(posedge clk);
    end
    sw <= 1'b0;
    st(`OP_BLOCK, 32'h2000, 64'h8000, 0, 0, 8'hf8, 1'b1);
    st(`OP_BLOCK, 32'h2000, 64'h8040, 0, 0, 8'hf1, 1'b0);
    st(`OP_BLOCK, 32'h2020, 64'h8000, 0, 0, 8'hf0, 1'b1);
    st(`OP_BLOCK, 32'h2000, 64'h8000, 0, 0, 8'h80, 1'b1);
    wb(1'b0, `REG_STATUS, 0, r);
    st(`OP_WORD, 32'h40, 64'h0, 64'h0, 64'h0, 8'h00, 1'b0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, irq_o);
    wb(1'b1, `REG_MASK, 32'h1, r);
    wb(1'b0, `REG_STATUS, 0, r);
    st(`OP_WORD, 32'h40, 64'h0, 64'h0, 64'h0, 8'h00, 1'b0);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq_o);
    wb(1'b0, `REG_STATUS, 0, r); chk("status bad op", 1, r[0]);
    chk("irq cleared", 0, irq_o);
    wb(1'b1, `REG_CTRL, 32'h0, r);
    repeat (2) @(posedge clk);
    chk("ready disabled", 0, issue_ready);
    end_of_test;
  end
endmodule
`default_nettype wire
